//--- verilog/pwr_mode_regs.svh
// Constants for the power saving mode controller
`ifndef PWR_MODE_REGS_SVH
`define PWR_MODE_REGS_SVH
// Halt opcode byte
`define HALT_OPCODE 8'h8E
// Wait-for-interrupt opcode byte
`define WFI_OPCODE 8'h8F
// Forced mask level on entry to a low power mode
`define MASK_LEVEL_ALL 2'b10
// Stabilisation delay lengths in master clock cycles
`define DELAY_SHORT_CYC 256
`define DELAY_LONG_CYC 4096
// Loaded counter values, derived from the cycle figures
`define DELAY_SHORT_LOAD 12'(`DELAY_SHORT_CYC - 1)
`define DELAY_LONG_LOAD 12'(`DELAY_LONG_CYC - 1)
// Wake source bit positions in the synchronised wake vector
`define WK_EXT_LSB 0
`define WK_EXT_W 4
`define WK_SPI 4
`define WK_ART 5
`define WK_RESET 6
`define WK_W 7
`endif

//--- verilog/pwr_mode_pkg.sv
// Types for the power saving mode controller
`default_nettype none
package pwr_mode_pkg;
  // Controller states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAIT,
    ST_ACTIVE_HALT,
    ST_HALT,
    ST_STARTUP,
    ST_HALT_REMAIN
  } pwr_state_e;
  // Clock gating and status bundle
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic timebase_clk_en;
    logic osc_enable;
    logic slow_active;
  } clk_ctrl_s;
endpackage
`default_nettype wire

//--- verilog/power_saving_mode_controller.sv
// Power saving mode controller: RUN, SLOW, WAIT, SLOW-WAIT, ACTIVE-HALT, HALT
// Functional notes
// R1: Reset selects RUN at full master clock
// R2: Slow mode divides master clock by 2..16
// R3: Wait during slow keeps reduced clock
// R4: Wait stops CPU, peripherals keep running
// R5: Wait entry forces mask level 10
// R6: Wait ends on any interrupt or reset
// R7: Wake service pushes condition codes first
// R8: Halt picks HALT or ACTIVE-HALT by enable
// R9: Active-halt exit by timebase, no delay
// R10: Halt entry forces mask, pending wakes
// R11: Active-halt keeps only oscillator and timebase
// R12: Active-halt never triggers watchdog reset
// R13: Enable cleared in delay falls into halt
// R14: Active-halt delay only on reset exit
// R15: Halt exit restarts oscillator, then delays
// R16: Halt stops oscillator, CPU and peripherals
// R17: Watchdog option decides reset or halt
// R18: Only listed sources wake from halt
// R19: Halt decoded from opcode 0x8E
// R20: SPI wakes halt only in slave mode
// R21: PWM timer wakes only with external clock
// R22: Wake events captured and synchronised safely
`timescale 1ns/1ps
`default_nettype none
`include "pwr_mode_regs.svh"
module power_saving_mode_controller
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  input wire logic slow_mode_enable,
  input wire logic [1:0] cpu_clock_prescale_sel,
  input wire logic osc_interrupt_enable,
  input wire logic delay_long_option,
  input wire logic watchdog_active,
  input wire logic watchdog_halt_option,
  input wire logic irq_pending,
  input wire logic timebase_irq,
  input wire logic [3:0] ext_wake_pin,
  input wire logic spi_irq,
  input wire logic spi_slave_mode,
  input wire logic art_irq,
  input wire logic art_ext_clk_mode,
  input wire logic reset_req_pin,
  output pwr_mode_pkg::clk_ctrl_s clk_ctrl,
  output pwr_mode_pkg::pwr_state_e state,
  output logic cc_mask_force,
  output logic [1:0] cc_mask_level,
  output logic wake_service,
  output logic sys_reset_pulse,
  output logic wdg_reset_req
);
  import pwr_mode_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Divider mask for the slow prescale select
  function automatic logic [3:0] prescale_mask(input logic [1:0] sel);
    logic [3:0] m;
    m = 4'h0;
    case (sel)
      2'd0: m = 4'h1;
      2'd1: m = 4'h3;
      2'd2: m = 4'h7;
      default: m = 4'hF;
    endcase
    return m;
  endfunction

  // Delay load value by option
  function automatic logic [11:0] delay_load(input logic long_opt);
    return long_opt ? `DELAY_LONG_LOAD : `DELAY_SHORT_LOAD;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Wake source synchronisers

  logic [`WK_W-1:0] wk_raw; // Raw asynchronous wake sources
  logic [`WK_W-1:0] wk_meta_q; // First stage, read only by second stage
  logic [`WK_W-1:0] wk_sync_q; // Safe wake levels

  assign wk_raw = {reset_req_pin, art_irq, spi_irq, ext_wake_pin};

  // Two-stage capture; the wake clock never stops here, only gated clocks do
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      wk_meta_q <= '0;
      wk_sync_q <= '0;
    end
    else
    begin
      wk_meta_q <= wk_raw; // R22
      wk_sync_q <= wk_meta_q; // R22
    end
  end

  logic ext_wake; // Any external line
  logic halt_wake; // Sources allowed to leave HALT
  logic reset_wake; // Reset request seen
  logic is_halt_op; // Halt instruction executed
  logic is_wfi_op; // Wait instruction executed

  assign ext_wake = |wk_sync_q[`WK_EXT_LSB +: `WK_EXT_W];
  // SPI only in slave mode, PWM timer only on external clock
  assign halt_wake = ext_wake
                   | (wk_sync_q[`WK_SPI] & spi_slave_mode) // R20
                   | (wk_sync_q[`WK_ART] & art_ext_clk_mode); // R18 R21
  assign reset_wake = wk_sync_q[`WK_RESET];
  assign is_halt_op = opcode_valid && (opcode == `HALT_OPCODE); // R19
  assign is_wfi_op = opcode_valid && (opcode == `WFI_OPCODE);

  ////////////////////////////////////////////////////////////////////////
  // Master clock divider

  logic [3:0] div_q; // Free divider counter
  logic slow_tick; // One-cycle enable at the slow rate

  // Divider runs on master clock
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end

  assign slow_tick = (div_q & prescale_mask(cpu_clock_prescale_sel))
                   == prescale_mask(cpu_clock_prescale_sel); // R2

  ////////////////////////////////////////////////////////////////////////
  // Mode state machine

  pwr_state_e state_q; // Current mode
  pwr_state_e state_d; // Next mode
  logic [11:0] dly_q; // Stabilisation delay counter
  logic guard_q; // Post active-halt delay window open
  logic rst_pend_q; // Startup ends in a reset, not a service
  logic enter_low; // Entering a low power mode this cycle
  logic dly_done; // Delay counter exhausted

  assign dly_done = (dly_q == 12'h000);

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
      begin
        if (guard_q && !osc_interrupt_enable)
          state_d = ST_HALT_REMAIN; // R13
        else if (is_wfi_op)
          state_d = ST_WAIT; // R3 R4
        else if (is_halt_op && osc_interrupt_enable)
          state_d = ST_ACTIVE_HALT; // R8 R12
        else if (is_halt_op && !(watchdog_active && watchdog_halt_option))
          state_d = ST_HALT; // R8 R17
      end
      ST_WAIT:
        if (irq_pending || halt_wake || timebase_irq || reset_wake)
          state_d = ST_RUN; // R6
      ST_ACTIVE_HALT:
        if (reset_wake)
          state_d = ST_STARTUP; // R14
        else if (timebase_irq)
          state_d = ST_RUN; // R9
      ST_HALT:
        if (reset_wake || halt_wake)
          state_d = ST_STARTUP; // R15 R18
      ST_STARTUP:
        if (dly_done)
          state_d = ST_RUN; // R15
      ST_HALT_REMAIN:
        if (dly_done)
          state_d = ST_RUN; // R13
      default:
        state_d = ST_RUN;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      state_q <= ST_RUN; // R1
    else
      state_q <= state_d;
  end

  assign enter_low = (state_q == ST_RUN)
                  && (state_d inside {ST_WAIT, ST_ACTIVE_HALT, ST_HALT});

  // Delay counter and active-halt guard window
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      dly_q <= 12'h000;
      guard_q <= 1'b0;
    end
    else if (state_q != ST_STARTUP && state_d == ST_STARTUP)
    begin
      dly_q <= delay_load(delay_long_option); // R15
      guard_q <= 1'b0;
    end
    else if (state_q == ST_ACTIVE_HALT && state_d == ST_RUN)
    begin
      // CPU resumes at once; counter only times the guard
      dly_q <= delay_load(delay_long_option); // R9 R13
      guard_q <= 1'b1;
    end
    else
    begin
      if (!dly_done)
        dly_q <= dly_q - 12'h001;
      if (dly_done || state_q != ST_RUN)
        guard_q <= 1'b0;
    end
  end

  // Reset-exit memory for the startup delay
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      rst_pend_q <= 1'b0;
    else if (state_q inside {ST_HALT, ST_ACTIVE_HALT} && state_d == ST_STARTUP)
      rst_pend_q <= reset_wake;
    else if (state_q == ST_STARTUP && dly_done)
      rst_pend_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock gating outputs

  clk_ctrl_s clk_q; // Registered gating bundle
  clk_ctrl_s clk_d; // Next gating bundle

  // Gating per next mode
  always_comb
  begin
    clk_d = '0;
    clk_d.slow_active = slow_mode_enable;
    case (state_d)
      ST_RUN:
      begin
        clk_d.cpu_clk_en = slow_mode_enable ? slow_tick : 1'b1; // R1 R2
        clk_d.periph_clk_en = slow_mode_enable ? slow_tick : 1'b1; // R2
        clk_d.timebase_clk_en = 1'b1;
        clk_d.osc_enable = 1'b1;
      end
      ST_WAIT:
      begin
        // Peripherals live on, slow rate kept if selected
        clk_d.periph_clk_en = slow_mode_enable ? slow_tick : 1'b1; // R3 R4
        clk_d.timebase_clk_en = 1'b1;
        clk_d.osc_enable = 1'b1;
      end
      ST_ACTIVE_HALT:
      begin
        clk_d.timebase_clk_en = 1'b1; // R11
        clk_d.osc_enable = 1'b1; // R11
      end
      ST_STARTUP:
        clk_d.osc_enable = 1'b1; // R15
      default:
        clk_d.osc_enable = 1'b0; // R16
    endcase
  end

  // Gating register
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      clk_q <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, timebase_clk_en: 1'b1,
                 osc_enable: 1'b1, slow_active: 1'b0};
    else
      clk_q <= clk_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU side pulses

  logic mask_q; // Mask force pulse
  logic wake_q; // Service request pulse
  logic rst_q; // Reset vector request pulse
  logic wdg_q; // Watchdog reset request pulse
  logic leave_run; // Returning to RUN from a low power mode

  assign leave_run = (state_q != ST_RUN) && (state_d == ST_RUN);

  // Mask force on entry to wait or halt modes
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      mask_q <= 1'b0;
    else
      mask_q <= enter_low; // R5 R10
  end

  // Service request: CPU pushes condition codes then loads priority
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      wake_q <= 1'b0;
    else
      wake_q <= leave_run && !reset_wake && !rst_pend_q; // R7
  end

  // Reset vector fetch request
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      rst_q <= 1'b0;
    else
      rst_q <= (state_q == ST_WAIT && reset_wake)
            || (state_q == ST_STARTUP && dly_done && rst_pend_q); // R6 R14
  end

  // Watchdog reset on halt when the option forbids halting
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      wdg_q <= 1'b0;
    else
      wdg_q <= (state_q == ST_RUN) && !guard_q && is_halt_op && !is_wfi_op
            && !osc_interrupt_enable && watchdog_active && watchdog_halt_option; // R17
  end

  assign clk_ctrl = clk_q;
  assign state = state_q;
  assign cc_mask_force = mask_q;
  assign cc_mask_level = `MASK_LEVEL_ALL;
  assign wake_service = wake_q;
  assign sys_reset_pulse = rst_q;
  assign wdg_reset_req = wdg_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_halt_mode_select;
    (state == ST_RUN && !guard_q && is_halt_op && osc_interrupt_enable)
      |=> state == ST_ACTIVE_HALT;
  endproperty
  a_halt_mode_select: assert property (p_halt_mode_select) else $error("halt with enable not active-halt"); // R8

  property p_wait_entry_mask;
    (state == ST_RUN && !guard_q && is_wfi_op) |=> (cc_mask_force && state == ST_WAIT);
  endproperty
  a_wait_entry_mask: assert property (p_wait_entry_mask) else $error("wait entry without mask force"); // R5

  property p_wait_cpu_stopped;
    state == ST_WAIT |-> ##1 !clk_ctrl.cpu_clk_en || state != ST_WAIT;
  endproperty
  a_wait_cpu_stopped: assert property (p_wait_cpu_stopped) else $error("cpu clocked in wait"); // R4

  property p_halt_osc_off;
    (state == ST_HALT && $past(state) == ST_HALT) |-> !clk_ctrl.osc_enable;
  endproperty
  a_halt_osc_off: assert property (p_halt_osc_off) else $error("oscillator running in halt"); // R16

  property p_ah_only_timebase;
    (state == ST_ACTIVE_HALT && $past(state) == ST_ACTIVE_HALT)
      |-> clk_ctrl.timebase_clk_en && !clk_ctrl.periph_clk_en && !clk_ctrl.cpu_clk_en;
  endproperty
  a_ah_only_timebase: assert property (p_ah_only_timebase) else $error("active-halt gating wrong"); // R11

  property p_ah_fast_exit;
    (state == ST_ACTIVE_HALT && timebase_irq && !reset_wake) |=> (state == ST_RUN && wake_service);
  endproperty
  a_ah_fast_exit: assert property (p_ah_fast_exit) else $error("active-halt exit delayed"); // R9

  logic [11:0] su_cnt_q; // Cycles spent so far in startup
  logic su_long_q; // Delay option seen at startup entry

  // Independent tally of the startup stay; too long for a repetition
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      su_cnt_q <= 12'h000;
      su_long_q <= 1'b0;
    end
    else if (state_q != ST_STARTUP)
    begin
      su_cnt_q <= 12'h000;
      su_long_q <= delay_long_option;
    end
    else
      su_cnt_q <= su_cnt_q + 12'h001;
  end

  property p_halt_startup_short;
    (state == ST_STARTUP && state_d == ST_RUN)
      |-> su_cnt_q == (su_long_q ? `DELAY_LONG_LOAD : `DELAY_SHORT_LOAD);
  endproperty
  a_halt_startup_short: assert property (p_halt_startup_short) else $error("startup delay length wrong"); // R15

  property p_halt_wake_filter;
    (state == ST_HALT && !ext_wake && !reset_wake && !spi_slave_mode && !art_ext_clk_mode)
      |=> state == ST_HALT;
  endproperty
  a_halt_wake_filter: assert property (p_halt_wake_filter) else $error("halt left by disallowed source"); // R18 R20 R21

  property p_guard_fall;
    (state == ST_RUN && guard_q && !osc_interrupt_enable) |=> state == ST_HALT_REMAIN;
  endproperty
  a_guard_fall: assert property (p_guard_fall) else $error("no halt fall in guard window"); // R13

  property p_ah_no_wdg;
    (state == ST_RUN && osc_interrupt_enable) |=> !wdg_reset_req;
  endproperty
  a_ah_no_wdg: assert property (p_ah_no_wdg) else $error("watchdog reset with enable set"); // R12

  property p_wdg_halt_reset;
    (state == ST_RUN && !guard_q && is_halt_op && !osc_interrupt_enable
      && watchdog_active && watchdog_halt_option) |=> wdg_reset_req && state == ST_RUN;
  endproperty
  a_wdg_halt_reset: assert property (p_wdg_halt_reset) else $error("watchdog halt option ignored"); // R17

  property p_slow_rate;
    (state == ST_RUN && $past(state) == ST_RUN && slow_mode_enable && $stable(cpu_clock_prescale_sel)
      && cpu_clock_prescale_sel == 2'd1 && clk_ctrl.cpu_clk_en) |=> !clk_ctrl.cpu_clk_en [*3];
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("slow divider rate wrong"); // R2

  c_wait_cycle: cover property (state == ST_WAIT ##[1:20] state == ST_RUN);
  c_ah_exit: cover property (state == ST_ACTIVE_HALT ##1 state == ST_RUN);
  c_halt_startup: cover property (state == ST_HALT ##1 state == ST_STARTUP);
  c_guard_halt: cover property (state == ST_HALT_REMAIN);
endmodule
`default_nettype wire

//--- verification/cpu_irq_model.sv
// Behavioural CPU core and interrupt controller facing the mode controller
`timescale 1ns/1ps
`default_nettype none
module cpu_irq_model
#(
  parameter logic [1:0] PRIO = 2'b11
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cc_mask_force,
  input wire logic [1:0] cc_mask_level,
  input wire logic wake_service,
  input wire logic sys_reset_pulse,
  input wire logic iret,
  output logic [1:0] mask_q,
  output int services,
  output int resets
);
  // Stacked condition code mask bits
  logic [1:0] stack_q[$];
  // Mask level, stack and event tallies; reset vector starts fully masked
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      mask_q <= 2'b11;
      services <= 0;
      resets <= 0;
    end
    else if (sys_reset_pulse)
    begin
      // Reset vector fetch after the start-up delay, or straight from wait on a reset request
      resets <= resets + 1;
      mask_q <= 2'b11;
    end
    else if (wake_service)
    begin
      // Push before servicing, then raise to the routine's level
      stack_q.push_back(mask_q);
      mask_q <= PRIO;
      services <= services + 1;
    end
    else if (iret && stack_q.size() > 0)
      mask_q <= stack_q.pop_back();
    else if (cc_mask_force)
      mask_q <= cc_mask_level;
  end
endmodule
`default_nettype wire

//--- verification/power_saving_mode_controller_tb.sv
// Self-checking bench for the power saving mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pwr_mode_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("BAD %s exp=%0h got=%0h", n, e, g); end end
module power_saving_mode_controller_tb;
  import pwr_mode_pkg::*;
  // Inputs, all given values at time zero
  logic clk_sys = 0;
  logic nrst = 0;
  logic opcode_valid = 0;
  logic [7:0] opcode = 8'h00;
  logic slow_mode_enable = 0;
  logic [1:0] cpu_clock_prescale_sel = 2'b00;
  logic osc_interrupt_enable = 0;
  logic delay_long_option = 0;
  logic watchdog_active = 0;
  logic watchdog_halt_option = 0;
  logic irq_pending = 0;
  logic timebase_irq = 0;
  logic [3:0] ext_wake_pin = 4'h0;
  logic spi_irq = 0;
  logic spi_slave_mode = 0;
  logic art_irq = 0;
  logic art_ext_clk_mode = 0;
  logic reset_req_pin = 0;
  logic iret = 0;
  // Outputs and model state
  clk_ctrl_s clk_ctrl;
  pwr_state_e state;
  logic cc_mask_force, wake_service, sys_reset_pulse, wdg_reset_req, seen;
  logic [1:0] cc_mask_level, mask_q;
  logic [15:0] lfsr = 16'h8BA9;
  int services, resets, n, k, c, s0;
  int errors = 0;
  int checks = 0;
  power_saving_mode_controller DUT (.clk_sys, .nrst, .opcode_valid, .opcode, .slow_mode_enable,
    .cpu_clock_prescale_sel, .osc_interrupt_enable, .delay_long_option, .watchdog_active,
    .watchdog_halt_option, .irq_pending, .timebase_irq, .ext_wake_pin, .spi_irq, .spi_slave_mode,
    .art_irq, .art_ext_clk_mode, .reset_req_pin, .clk_ctrl, .state, .cc_mask_force,
    .cc_mask_level, .wake_service, .sys_reset_pulse, .wdg_reset_req);
  cpu_irq_model cpu (.clk_sys, .nrst, .cc_mask_force, .cc_mask_level, .wake_service,
    .sys_reset_pulse, .iret, .mask_q, .services, .resets);
  ////////////////////////////////////////////////////////////////////////////////
  // Reference model of mode choice on halt
  function automatic pwr_state_e halt_to(logic [2:0] cfg);
    if (cfg[2])
      return ST_ACTIVE_HALT;
    return (cfg[1] & cfg[0]) ? ST_RUN : ST_HALT;
  endfunction
  // Pseudo-random source, Fibonacci taps
  function automatic logic [15:0] step(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cyc(int m);
    repeat (m) @(negedge clk_sys);
  endtask
  // One executed opcode; returns after the taking edge
  task automatic exec(logic [7:0] op);
    @(negedge clk_sys);
    opcode = op;
    opcode_valid = 1;
    @(negedge clk_sys);
    opcode_valid = 0;
  endtask
  // Bounded wait for a mode, cycles spent left in n
  task automatic wait_st(pwr_state_e st, int lim);
    n = 0;
    while (state !== st && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  // Start-up delay length, then the service or reset fetch
  task automatic startup(int d, bit rst);
    int r0;
    int v0;
    r0 = resets;
    v0 = services;
    wait_st(ST_STARTUP, 8);
    reset_req_pin = 0;
    `CHK("osc on", 1'b1, clk_ctrl.osc_enable)
    n = 0;
    while (state === ST_STARTUP && n < 5000)
    begin
      cyc(1);
      n++;
    end
    `CHK("delay", d, n)
    cyc(2);
    `CHK("fetch", rst ? r0 + 1 : v0 + 1, rst ? resets : services)
  endtask
  task automatic rst(int m);
    nrst = 0;
    cyc(m);
    nrst = 1;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
    forever #20 clk_sys = ~clk_sys;
  // Hang guard, well past the longest delay chain
  initial
  begin
    #800000;
    errors++;
    wrap_up();
  end
  initial
  begin
    rst(16);
    `CHK("rst mode", ST_RUN, state)
    `CHK("rst clk", 5'b11110, clk_ctrl)
    $display("test reset done");
    // Slow divide for every prescale code
    slow_mode_enable = 1;
    for (int s = 0; s < 4; s++)
    begin
      cpu_clock_prescale_sel = 2'(s);
      cyc(4);
      k = 0;
      repeat (32)
      begin
        cyc(1);
        k += clk_ctrl.cpu_clk_en + clk_ctrl.periph_clk_en;
      end
      `CHK("slow div", 64 >> (s + 1), k)
      `CHK("slow flag", 1'b1, clk_ctrl.slow_active)
    end
    $display("test slow done");
    // Wait and slow-wait, refused halt inside, wake and return
    for (int s = 0; s < 2; s++)
    begin
      slow_mode_enable = s[0];
      cyc(4);
      exec(`WFI_OPCODE);
      `CHK("wait", ST_WAIT, state)
      `CHK("force", 1'b1, cc_mask_force)
      cyc(1);
      k = 0;
      c = 0;
      repeat (32)
      begin
        cyc(1);
        k += clk_ctrl.periph_clk_en;
        c += clk_ctrl.cpu_clk_en;
      end
      `CHK("periph", s ? 2 : 32, k)
      `CHK("cpu off", 0, c)
      `CHK("mask", `MASK_LEVEL_ALL, mask_q)
      exec(`HALT_OPCODE);
      `CHK("no halt", ST_WAIT, state)
      s0 = services;
      irq_pending = 1;
      cyc(1);
      irq_pending = 0;
      `CHK("wake", ST_RUN, state)
      cyc(2);
      `CHK("serviced", s0 + 1, services)
      iret = 1;
      cyc(1);
      iret = 0;
      cyc(1);
      `CHK("popped", `MASK_LEVEL_ALL, mask_q)
    end
    slow_mode_enable = 0;
    $display("test wait done");
    // Random opcodes that decode to neither mode instruction
    repeat (16)
    begin
      lfsr = step(lfsr);
      exec((lfsr[7:1] == 7'h47) ? lfsr[7:0] ^ 8'h10 : lfsr[7:0]);
      `CHK("decode", ST_RUN, state)
    end
    $display("test decode done");
    // Halt outcome table, left by the reset pin, or by nrst after the watchdog reset case
    for (int i = 0; i < 8; i++)
    begin
      {osc_interrupt_enable, watchdog_active, watchdog_halt_option} = 3'(i);
      exec(`HALT_OPCODE);
      `CHK("halt mode", halt_to(3'(i)), state)
      seen = wdg_reset_req;
      cyc(1);
      seen |= wdg_reset_req;
      `CHK("wdg", halt_to(3'(i)) == ST_RUN, seen)
      if (halt_to(3'(i)) == ST_RUN)
      begin
        rst(2);
        `CHK("rerun", ST_RUN, state)
      end
      else
      begin
        reset_req_pin = 1;
        startup(`DELAY_SHORT_CYC, 1);
      end
    end
    watchdog_active = 0;
    $display("test halt table done");
    // Active-halt: clocks, foreign source, instant wake, guard window
    osc_interrupt_enable = 1;
    exec(`HALT_OPCODE);
    `CHK("ah clk", 4'b0011, clk_ctrl[4:1])
    `CHK("ah force", 1'b1, cc_mask_force)
    cyc(1);
    {spi_slave_mode, spi_irq} = 2'b11;
    cyc(6);
    `CHK("ah hold", ST_ACTIVE_HALT, state)
    {spi_slave_mode, spi_irq} = 2'b00;
    timebase_irq = 1;
    cyc(1);
    timebase_irq = 0;
    `CHK("ah wake", ST_RUN, state)
    cyc(3);
    osc_interrupt_enable = 0;
    wait_st(ST_HALT_REMAIN, 3);
    `CHK("remain", ST_HALT_REMAIN, state)
    `CHK("remain osc", 1'b0, clk_ctrl.osc_enable)
    wait_st(ST_RUN, 300);
    `CHK("remain end", 1, n > 200 && state === ST_RUN)
    osc_interrupt_enable = 1;
    timebase_irq = 1;
    exec(`HALT_OPCODE);
    wait_st(ST_RUN, 3);
    `CHK("pending", ST_RUN, state)
    timebase_irq = 0;
    osc_interrupt_enable = 0;
    cyc(300);
    $display("test active halt done");
    // Halt wake sources: unqualified ones ignored, then the qualified one
    for (int w = 0; w < 3; w++)
    begin
      exec(`HALT_OPCODE);
      `CHK("halt clk", 4'b0000, clk_ctrl[4:1])
      // Timer, then serial, then two non-waking sources with a pin
      {spi_irq, art_irq, irq_pending, timebase_irq} = (w == 2) ? 4'b0011 : 4'b0100 << w;
      cyc(8);
      `CHK("halt hold", ST_HALT, state)
      // Qualify the source that is raised: timer clock, then slave mode
      {spi_slave_mode, art_ext_clk_mode} = 2'b01 << w;
      delay_long_option = (w == 2);
      if (w == 2)
        ext_wake_pin = lfsr[3:0] | 4'h1;
      startup(w == 2 ? `DELAY_LONG_CYC : `DELAY_SHORT_CYC, 0);
      {spi_irq, art_irq, irq_pending, timebase_irq, spi_slave_mode, art_ext_clk_mode} = 6'h00;
      ext_wake_pin = 4'h0;
      cyc(4);
    end
    $display("test halt wake done");
    wrap_up();
  end
endmodule
`default_nettype wire
